//--- hw/mpss_host.sv
module mpss_host
    import mpss_pkg::*;
#(
    parameter int WAIT_CYCLES = mpss_pkg::EN_TO_RST_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // user side
    input wire logic power_up_req,
    input wire logic power_down_req,
    output logic powered,
    output logic busy,
    // link
    mpss_if.host link
);
    import mpss_pkg::*;
    // ************************************************************
    // sequencer
    // ************************************************************
    mpss_host_state_type state_reg, state_next;
    logic [mpss_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic en_reg, en_next;
    logic rstn_reg, rstn_next;
    logic io_reg, io_next;
    logic busy_reg, busy_next;

    // next-state logic; down wins over up so a late abort is honoured
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        en_next = en_reg;
        rstn_next = rstn_reg;
        io_next = io_reg;
        case (state_reg)
            MPSS_H_DOWN:
            begin
                io_next = 1'b1; // io supply first, enable no earlier R6
                if (power_up_req && !power_down_req && io_reg)
                begin
                    en_next = 1'b1; // R1
                    cnt_next = '0;
                    state_next = MPSS_H_WAIT;
                end
            end
            MPSS_H_WAIT:
            begin
                if (power_down_req)
                begin
                    en_next = 1'b0; // R13
                    rstn_next = 1'b0; // R13
                    state_next = MPSS_H_DOWN;
                end
                else if (cnt_reg >= CNT_W'(WAIT_CYCLES - 1))
                begin
                    rstn_next = 1'b1; // R7 R12
                    state_next = MPSS_H_UP;
                end
                else
                    cnt_next = cnt_reg + 1'b1; // R12
            end
            MPSS_H_UP:
            begin
                if (power_down_req)
                begin
                    en_next = 1'b0; // R5 R9
                    rstn_next = 1'b0; // R5 R9
                    state_next = MPSS_H_DOWN;
                end
            end
            default:
            begin
                state_next = MPSS_H_DOWN;
                en_next = 1'b0;
                rstn_next = 1'b0;
            end
        endcase
        // busy follows the state it is entering, so it lands with that state
        busy_next = (state_next == MPSS_H_WAIT);
    end

    // all pins driven to defined levels from reset R8
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= MPSS_H_DOWN;
            cnt_reg <= '0;
            en_reg <= 1'b0;
            rstn_reg <= 1'b0;
            io_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            en_reg <= en_next;
            rstn_reg <= rstn_next;
            io_reg <= io_next;
            busy_reg <= busy_next;
        end
    end

    // io supply stays on while powered R2
    assign link.io_supply = io_reg;
    assign link.core_power_en = en_reg;
    assign link.hard_reset_low = rstn_reg;
    assign powered = rstn_reg;
    assign busy = busy_reg;
endmodule : mpss_host

//--- hw/mpss_pkg.sv
package mpss_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int EN_TO_RST_MS = 5;
    // least time, rounded up to whole cycles
    localparam int EN_TO_RST_CYCLES = (EN_TO_RST_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 24;
    // ************************************************************
    // pin groups
    // ************************************************************
    localparam int IO_PINS = 8;
    // ************************************************************
    // device power states
    // ************************************************************
    typedef enum logic [2:0]
    {
        MPSS_OFF = 3'b000,
        MPSS_RESET = 3'b001,
        MPSS_DEFAULT = 3'b011,
        MPSS_IDLE = 3'b010,
        MPSS_RX = 3'b110,
        MPSS_TX = 3'b111
    } mpss_dev_state_type;
    // host sequencer states
    typedef enum logic [1:0]
    {
        MPSS_H_DOWN = 2'b00,
        MPSS_H_WAIT = 2'b01,
        MPSS_H_UP = 2'b11
    } mpss_host_state_type;
endpackage : mpss_pkg

//--- hw/mpss_if.sv
interface mpss_if;
    logic io_supply;
    logic core_power_en;
    logic hard_reset_low;
    modport host
    (
        output io_supply,
        output core_power_en,
        output hard_reset_low
    );
    modport device
    (
        input io_supply,
        input core_power_en,
        input hard_reset_low
    );
endinterface : mpss_if

//--- hw/mpss_device.sv
// Notes on behaviour
// R1: enable high powers core, low powers off
// R2: host keeps io supply and enable high
// R3: core-off removes supply; idle neither sends nor receives
// R4: idle state distinct from transmit and receive
// R5: host lowers reset and enable for core-off
// R6: enable never rises before io supply
// R7: reset release at least 5 ms after enable
// R8: host always drives reset and enable
// R9: reset and enable fall together, before supply
// R10: off disables pins; active uses firmware settings
// R11: in reset pulls only; defaults inputs plus pulls
// R12: host counts the enable-to-reset gap
// R13: power-down aborts pending power-up immediately
module mpss_device
    import mpss_pkg::*;
#(
    parameter int PINS = mpss_pkg::IO_PINS
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // link
    mpss_if.device link,
    // firmware side
    input wire logic fw_ready,
    input wire logic fw_tx_req,
    input wire logic fw_rx_req,
    input wire logic [PINS-1:0] fw_out_en,
    input wire logic [PINS-1:0] fw_pull_en,
    // pin control and status
    output logic core_supply_on,
    output logic [PINS-1:0] pin_out_en,
    output logic [PINS-1:0] pin_in_en,
    output logic [PINS-1:0] pin_pull_en,
    output mpss_pkg::mpss_dev_state_type state
);
    import mpss_pkg::*;
    // ************************************************************
    // power state
    // ************************************************************
    mpss_dev_state_type state_reg, state_next;
    logic sup_reg, sup_next;
    logic [PINS-1:0] oe_reg, oe_next, ie_reg, ie_next, pu_reg, pu_next;

    // pins derive from the next state so they track it exactly
    always_comb
    begin
        state_next = state_reg;
        if (!link.io_supply || !link.core_power_en)
            state_next = MPSS_OFF; // R1 R3
        else if (!link.hard_reset_low)
            state_next = MPSS_RESET;
        else
        begin
            case (state_reg)
                MPSS_OFF, MPSS_RESET: state_next = MPSS_DEFAULT;
                MPSS_DEFAULT: state_next = fw_ready ? MPSS_IDLE : MPSS_DEFAULT;
                // idle only while no frame moves R4
                MPSS_IDLE, MPSS_RX, MPSS_TX:
                    state_next = fw_tx_req ? MPSS_TX : (fw_rx_req ? MPSS_RX : MPSS_IDLE);
                default: state_next = MPSS_OFF;
            endcase
        end
        sup_next = (state_next != MPSS_OFF); // R1 R3
        case (state_next)
            MPSS_OFF:
            begin
                oe_next = '0; // R10
                ie_next = '0;
                pu_next = '0;
            end
            MPSS_RESET:
            begin
                oe_next = '0; // R11
                ie_next = '0;
                pu_next = '1;
            end
            MPSS_DEFAULT:
            begin
                oe_next = '0; // R11
                ie_next = '1;
                pu_next = '1;
            end
            default:
            begin
                oe_next = fw_out_en; // R10
                ie_next = ~fw_out_en; // R10
                pu_next = fw_pull_en;
            end
        endcase
    end

    // registered so each output comes from a flip-flop
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= MPSS_OFF;
            sup_reg <= 1'b0;
            oe_reg <= '0;
            ie_reg <= '0;
            pu_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            sup_reg <= sup_next;
            oe_reg <= oe_next;
            ie_reg <= ie_next;
            pu_reg <= pu_next;
        end
    end

    assign state = state_reg;
    assign core_supply_on = sup_reg;
    assign pin_out_en = oe_reg;
    assign pin_in_en = ie_reg;
    assign pin_pull_en = pu_reg;
endmodule : mpss_device

//--- tb/mpss_properties.sv
module mpss_properties
#(
    parameter int WAIT_CYCLES = 8
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // link pins
    input wire logic io_supply,
    input wire logic core_power_en,
    input wire logic hard_reset_low
);
    timeunit 1ns;
    timeprecision 1ns;
    // wraps after 256, only read at release
    logic [7:0] gap_reg;
    logic [7:0] gap_next;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // cycles with enable high
    always_comb
        gap_next = core_power_en ? gap_reg + 8'h01 : 8'h00;
    // register the count
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            gap_reg <= 8'h00;
        else
            gap_reg <= gap_next;
    // ****
    // checks
    // ****
    a_en_needs_supply: assert property (core_power_en |-> io_supply)
        else $error("enable without supply");
    a_gap_exact: assert property ($rose(hard_reset_low) |-> gap_reg == 8'(WAIT_CYCLES))
        else $error("release gap wrong");
    a_gap_enable: assert property ($rose(hard_reset_low) |-> $past(core_power_en, WAIT_CYCLES))
        else $error("release too early");
    a_release_needs_en: assert property (hard_reset_low |-> core_power_en)
        else $error("reset high, enable low");
    a_fall_together: assert property ($fell(hard_reset_low) |-> $fell(core_power_en))
        else $error("reset fell alone");
    a_supply_stays: assert property (io_supply |=> io_supply)
        else $error("supply dropped");
    a_supply_rises: assert property (!io_supply |=> io_supply)
        else $error("supply not raised");
    a_rise_in_reset: assert property ($rose(core_power_en) |-> !hard_reset_low)
        else $error("enable rose out of reset");
    c_release: cover property ($rose(hard_reset_low));
    c_down: cover property ($fell(hard_reset_low));
    c_abort: cover property ($fell(core_power_en) && !$past(hard_reset_low));
endmodule : mpss_properties

//--- tb/module_power_state_sequencer_tb.sv
module module_power_state_sequencer_tb
    import mpss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WAIT = 8;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic power_up_req = 1'b0, power_down_req = 1'b0;
    logic fw_ready = 1'b0, fw_tx_req = 1'b0, fw_rx_req = 1'b0;
    logic [7:0] fw_out_en = 8'h00, fw_pull_en = 8'h00;
    logic powered, busy, core_supply_on;
    logic [7:0] pin_out_en, pin_in_en, pin_pull_en;
    mpss_dev_state_type state;
    int n_mismatch = 0, check_count = 0, n;
    wire logic [23:0] pins = {pin_out_en, pin_in_en, pin_pull_en};
    mpss_if link();
    mpss_host #(.WAIT_CYCLES(WAIT)) mpss_host_i(.clk, .reset_n, .power_up_req,
        .power_down_req, .powered, .busy, .link);
    mpss_device mpss_device_i(.clk, .reset_n, .link, .fw_ready, .fw_tx_req, .fw_rx_req,
        .fw_out_en, .fw_pull_en, .core_supply_on, .pin_out_en, .pin_in_en, .pin_pull_en,
        .state);
    mpss_properties #(.WAIT_CYCLES(WAIT)) mpss_properties_i(.clk, .reset_n,
        .io_supply(link.io_supply), .core_power_en(link.core_power_en),
        .hard_reset_low(link.hard_reset_low));
    // 50 ns clock
    always #25 clk = ~clk;
`define CHK(a, e) chk(64'(a), 64'(e))
    // ****
    // helpers
    // ****
    task automatic chk(input logic [63:0] a, input logic [63:0] e);
        check_count++;
        if (a !== e)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, a, e);
        end
    endtask : chk
    // drive and sample off the edge
    task automatic step();
        @(posedge clk);
        #5;
    endtask : step
    // input buffer is the inverse of the output driver
    function automatic logic [23:0] exp_pins(input logic [7:0] o, input logic [7:0] p);
        return {o, ~o, p};
    endfunction : exp_pins
    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    task automatic power_up();
        power_up_req = 1'b1;
        n = 0;
        while (!link.core_power_en && n < 5)
        begin
            step();
            n++;
        end
        power_up_req = 1'b0;
        `CHK(link.hard_reset_low, 1'b0);
        n = 0;
        do
        begin
            step();
            n++;
            if (n == 1)
            begin
                `CHK(pins, 24'h0000ff);
                `CHK(busy, 1'b1);
            end
        end while (!link.hard_reset_low && n < 20);
        `CHK(n, WAIT);
        `CHK(powered, 1'b1);
        `CHK(busy, 1'b0);
        step();
        `CHK(state, MPSS_DEFAULT);
        `CHK(pins, 24'h00ffff);
        `CHK(core_supply_on, 1'b1);
    endtask : power_up
    task automatic power_down();
        power_down_req = 1'b1;
        step();
        `CHK({link.core_power_en, link.hard_reset_low}, 2'b00);
        power_down_req = 1'b0;
        step();
        `CHK(state, MPSS_OFF);
        `CHK({core_supply_on, pins}, 25'h0);
    endtask : power_down
    // main sequence
    initial
    begin
        n = $urandom(32'hb7a318e0);
        repeat (10) @(posedge clk);
        #5 reset_n = 1'b1;
        step();
        `CHK(pins, 24'h0);
        step();
        `CHK(link.io_supply, 1'b1);
        repeat (4)
        begin
            power_up();
            fw_out_en = 8'($urandom);
            fw_pull_en = 8'($urandom);
            fw_ready = 1'b1;
            step();
            step();
            `CHK(state, MPSS_IDLE);
            `CHK(pins, exp_pins(fw_out_en, fw_pull_en));
            for (int m = 1; m < 4; m++)
            begin
                {fw_rx_req, fw_tx_req} = 2'(m);
                step();
                step();
                `CHK(state, m[0] ? MPSS_TX : MPSS_RX);
            end
            {fw_ready, fw_rx_req, fw_tx_req} = 3'h0;
            power_down();
        end
        // down during the wait, up still held
        power_up_req = 1'b1;
        repeat (3) step();
        `CHK(busy, 1'b1);
        power_down_req = 1'b1;
        step();
        `CHK({link.core_power_en, link.hard_reset_low, powered, busy}, 4'h0);
        {power_up_req, power_down_req} = 2'b00;
        step();
        power_up();
        power_down();
        results();
    end
    // hang guard, run needs about a hundred cycles
    initial
    begin
        #(50 * 2000);
        n_mismatch++;
        results();
    end
endmodule : module_power_state_sequencer_tb
